// ---- common/apcu_if.sv ----
/*
  Task-file link between host controller and device.
  Assumes both ends share core_clk_i; writes and reads take one cycle.
*/
interface apcu_if;
  logic [9:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic intrq;

  modport host (output addr, output wr, output rd, output wdata, input rdata, input intrq);
  modport dev (input addr, input wr, input rd, input wdata, output rdata, output intrq);
endinterface

// ---- common/apcu_pkg.sv ----
/*
  Constants shared by both ends of the power-mode command unit: task-file
  offsets, command codes, status bits, timer decode figures and the clock rate.
  Assumes a single 200 MHz clock common to host controller and device.
*/
package apcu_pkg;
  // ----------------------------------------------------------------------
  // Task-file offsets
  // ----------------------------------------------------------------------
  localparam logic [9:0] TF_SECTOR_COUNT = 10'h1f2;
  localparam logic [9:0] TF_DRIVE_HEAD = 10'h1f6;
  localparam logic [9:0] TF_COMMAND = 10'h1f7;
  localparam logic [9:0] TF_STATUS = 10'h1f7;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE_A = 8'h97;
  localparam logic [7:0] CMD_IDLE_B = 8'he3;
  localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B = 8'he1;
  localparam logic [7:0] CMD_STBY_A = 8'h96;
  localparam logic [7:0] CMD_STBY_B = 8'he2;
  localparam logic [7:0] CMD_STBY_IMM_A = 8'h94;
  localparam logic [7:0] CMD_STBY_IMM_B = 8'he0;

  // ----------------------------------------------------------------------
  // Device condition bits
  // ----------------------------------------------------------------------
  localparam int BUSY_BIT = 7;
  localparam int READY_BIT = 6;
  localparam int ERROR_BIT = 0;
  localparam int DRIVE_SEL_BIT = 4;

  // ----------------------------------------------------------------------
  // Timer decode
  // ----------------------------------------------------------------------
  localparam logic [7:0] SC_DISABLE = 8'h00;
  localparam logic [7:0] SC_SHORT_MAX = 8'hf0;
  localparam logic [7:0] SC_LONG_MAX = 8'hfb;
  localparam logic [7:0] SC_21MIN = 8'hfc;
  localparam logic [7:0] SC_8HOUR = 8'hfd;
  localparam logic [15:0] SHORT_STEP_S = 16'h0005;
  localparam logic [15:0] LONG_STEP_S = 16'h0708;
  localparam logic [15:0] PERIOD_21MIN_S = 16'h04ec;
  localparam logic [15:0] PERIOD_8HOUR_S = 16'h7080;
  localparam logic [15:0] PERIOD_21M15S_S = 16'h04fb;

  // ----------------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_S;

  typedef enum logic [1:0] {
    APCU_KIND_NONE = 2'b00,
    APCU_KIND_IDLE = 2'b01,
    APCU_KIND_STBY = 2'b10
  } apcu_kind_e;
endpackage

// ---- design/apcu_device.sv ----
/*
  Device end: decodes the four power-mode commands written to the task file,
  keeps busy and the interrupt, requests spindle spin-up and spin-down and runs
  the automatic power-down countdown.
  Assumes a host on the same clock; the spindle reports rotation on a pin.
*/
module apcu_device #(
  parameter int TICK_CYCLES = apcu_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Task-file link
  apcu_if.dev tf,
  // Spindle
  input wire logic spindle_rotating_i,
  input wire logic seek_cmd_i,
  output logic spin_up_req_o,
  output logic spin_down_req_o,
  // Condition
  output logic standby_mode_o,
  output logic auto_pd_en_o,
  output logic seek_go_o
);
  logic [7:0] sc_ff, dh_ff;
  logic busy_ff, intrq_ff, standby_ff, apd_en_ff, run_ff;
  logic [15:0] period_ff, remain_ff;
  logic [31:0] pre_ff;
  logic up_ff, down_ff, seek_pend_ff, seek_go_ff;
  logic [2:0] rot_sync_ff;
  logic rot_ff;
  apcu_pkg::apcu_kind_e kind_ff;
  logic imm_ff;
  logic cmd_wr, is_idle, is_idle_imm, is_stby, is_stby_imm, tick, expire;
  logic [15:0] decoded;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  assign cmd_wr = tf.wr && tf.addr == apcu_pkg::TF_COMMAND && !busy_ff;
  assign is_idle = tf.wdata == apcu_pkg::CMD_IDLE_A || tf.wdata == apcu_pkg::CMD_IDLE_B;
  assign is_idle_imm = tf.wdata == apcu_pkg::CMD_IDLE_IMM_A || tf.wdata == apcu_pkg::CMD_IDLE_IMM_B;
  assign is_stby = tf.wdata == apcu_pkg::CMD_STBY_A || tf.wdata == apcu_pkg::CMD_STBY_B;
  assign is_stby_imm = tf.wdata == apcu_pkg::CMD_STBY_IMM_A || tf.wdata == apcu_pkg::CMD_STBY_IMM_B;

  always_comb begin
    decoded = apcu_pkg::PERIOD_21M15S_S;
    if (sc_ff <= apcu_pkg::SC_SHORT_MAX)
      decoded = 16'({8'h00, sc_ff} * apcu_pkg::SHORT_STEP_S);
    else if (sc_ff <= apcu_pkg::SC_LONG_MAX)
      decoded = 16'({8'h00, sc_ff - apcu_pkg::SC_SHORT_MAX} * apcu_pkg::LONG_STEP_S);
    else if (sc_ff == apcu_pkg::SC_21MIN)
      decoded = apcu_pkg::PERIOD_21MIN_S;
    else if (sc_ff == apcu_pkg::SC_8HOUR)
      decoded = apcu_pkg::PERIOD_8HOUR_S;
  end

  assign tf.rdata = tf.addr == apcu_pkg::TF_SECTOR_COUNT ? sc_ff :
                    tf.addr == apcu_pkg::TF_DRIVE_HEAD ? dh_ff :
                    tf.addr == apcu_pkg::TF_STATUS ?
                    {busy_ff, ~busy_ff, 6'h00} : 8'h00;
  assign tf.intrq = intrq_ff;
  assign spin_up_req_o = up_ff;
  assign spin_down_req_o = down_ff;
  assign standby_mode_o = standby_ff;
  assign auto_pd_en_o = apd_en_ff;
  assign seek_go_o = seek_go_ff;

  // ----------------------------------------------------------------------
  // Task-file registers and spindle input synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sc_ff <= 8'h00;
      dh_ff <= 8'h00;
    end else if (tf.wr && !busy_ff) begin
      if (tf.addr == apcu_pkg::TF_SECTOR_COUNT) sc_ff <= tf.wdata;
      if (tf.addr == apcu_pkg::TF_DRIVE_HEAD) dh_ff <= tf.wdata;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rot_sync_ff <= 3'b000;
      rot_ff <= 1'b0;
    end else begin
      rot_sync_ff <= {rot_sync_ff[1:0], spindle_rotating_i};
      if (rot_sync_ff[1] == rot_sync_ff[2]) rot_ff <= rot_sync_ff[2];
    end
  end

  // ----------------------------------------------------------------------
  // Busy and interrupt: busy for one cycle, then complete at once, because
  // completion does not wait for the spindle transition.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      intrq_ff <= 1'b0;
      kind_ff <= apcu_pkg::APCU_KIND_NONE;
      imm_ff <= 1'b0;
    end else begin
      if (cmd_wr) begin
        busy_ff <= 1'b1;
        intrq_ff <= 1'b0;
        imm_ff <= is_idle_imm | is_stby_imm;
        kind_ff <= (is_idle | is_idle_imm) ? apcu_pkg::APCU_KIND_IDLE :
                   (is_stby | is_stby_imm) ? apcu_pkg::APCU_KIND_STBY : apcu_pkg::APCU_KIND_NONE;
      end else if (busy_ff) begin
        busy_ff <= 1'b0;
        intrq_ff <= 1'b1;
      end else if (tf.rd && tf.addr == apcu_pkg::TF_STATUS) begin
        intrq_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power mode and spindle requests
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      standby_ff <= 1'b0;
      up_ff <= 1'b0;
      down_ff <= 1'b0;
      seek_pend_ff <= 1'b0;
      seek_go_ff <= 1'b0;
    end else begin
      seek_go_ff <= 1'b0;
      if (busy_ff && kind_ff == apcu_pkg::APCU_KIND_IDLE) begin
        standby_ff <= 1'b0;
        up_ff <= ~rot_ff;
        down_ff <= 1'b0;
      end else if (busy_ff && kind_ff == apcu_pkg::APCU_KIND_STBY) begin
        standby_ff <= 1'b1;
        down_ff <= rot_ff;
        up_ff <= 1'b0;
      end else if (expire) begin
        standby_ff <= 1'b1;
        down_ff <= rot_ff;
        up_ff <= 1'b0;
      end else if (seek_cmd_i && !seek_pend_ff) begin
        seek_pend_ff <= 1'b1;
        up_ff <= ~rot_ff;
        down_ff <= 1'b0;
      end else if (seek_pend_ff && rot_ff) begin
        seek_pend_ff <= 1'b0;
        seek_go_ff <= 1'b1;
        standby_ff <= 1'b0;
        up_ff <= 1'b0;
      end else begin
        if (up_ff && rot_ff) up_ff <= 1'b0;
        if (down_ff && !rot_ff) down_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Automatic power-down countdown
  // ----------------------------------------------------------------------
  assign tick = pre_ff == 32'(TICK_CYCLES - 1);
  assign expire = run_ff && !busy_ff && !standby_ff && tick && remain_ff == 16'h0001;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pre_ff <= 32'h0000_0000;
    end else if (tick || cmd_wr) begin
      pre_ff <= 32'h0000_0000;
    end else begin
      pre_ff <= pre_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      apd_en_ff <= 1'b0;
      period_ff <= 16'h0000;
      remain_ff <= 16'h0000;
      run_ff <= 1'b0;
    end else begin
      if (cmd_wr) begin
        remain_ff <= period_ff;
      end else if (busy_ff && !imm_ff && kind_ff != apcu_pkg::APCU_KIND_NONE) begin
        apd_en_ff <= sc_ff != apcu_pkg::SC_DISABLE;
        period_ff <= decoded;
        remain_ff <= decoded;
        run_ff <= sc_ff != apcu_pkg::SC_DISABLE && kind_ff == apcu_pkg::APCU_KIND_IDLE;
      end else if (busy_ff && kind_ff == apcu_pkg::APCU_KIND_STBY) begin
        run_ff <= 1'b0;
      end else if (busy_ff && kind_ff == apcu_pkg::APCU_KIND_IDLE) begin
        run_ff <= apd_en_ff;
        remain_ff <= period_ff;
      end else if (busy_ff) begin
        run_ff <= apd_en_ff && !standby_ff;
        remain_ff <= period_ff;
      end else if (expire) begin
        run_ff <= 1'b0;
      end else if (seek_go_ff && apd_en_ff) begin
        run_ff <= 1'b1;
        remain_ff <= period_ff;
      end else if (run_ff && tick) begin
        remain_ff <= remain_ff - 16'h0001;
      end
    end
  end
endmodule

// ---- design/apcu_host.sv ----
/*
  Host controller end: takes orders over Avalon-MM and plays them out as
  task-file cycles to the device.
  Assumes a device on the same clock that answers reads in the same cycle.
  Avalon map (word addresses): 0 sector count, 1 drive/head, 2 command
  (write starts the sequence), 3 status (read: last device condition, bit 8
  sticky interrupt seen, bit 9 sequence busy; a write clears bit 8).
*/
module apcu_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Task-file link
  apcu_if.host tf
);
  typedef enum logic [1:0] {
    APCU_H_IDLE = 2'b00,
    APCU_H_SC = 2'b01,
    APCU_H_DH = 2'b10,
    APCU_H_CMD = 2'b11
  } apcu_h_state_e;

  apcu_h_state_e state_ff;
  logic [7:0] sc_ff, dh_ff, cmd_ff, cond_ff;
  logic irq_seen_ff, ack_ff;
  logic [9:0] addr_ff;
  logic wr_ff, rd_ff;
  logic [7:0] wdata_ff;
  logic [31:0] rdata_ff;
  logic acc;
  logic wr_acc;
  logic nxt_ack;
  logic wait_ff;

  assign acc = (avs_read_i | avs_write_i) & ~ack_ff;
  // A write lands only at the edge where the master sees waitrequest low.
  assign wr_acc = avs_write_i & ack_ff;
  assign nxt_ack = acc & ~(avs_write_i && avs_address_i == 2'h2 && state_ff != APCU_H_IDLE);
  assign avs_waitrequest_o = wait_ff;
  assign avs_readdata_o = rdata_ff;
  assign tf.addr = addr_ff;
  assign tf.wr = wr_ff;
  assign tf.rd = rd_ff;
  assign tf.wdata = wdata_ff;

  // ----------------------------------------------------------------------
  // Avalon slave: one wait cycle, then acknowledge; a command write waits while the sequencer runs.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      wait_ff <= ~nxt_ack;
      rdata_ff <= 32'h0000_0000;
      case (avs_address_i)
        2'h0: rdata_ff <= {24'h00_0000, sc_ff};
        2'h1: rdata_ff <= {24'h00_0000, dh_ff};
        2'h2: rdata_ff <= {24'h00_0000, cmd_ff};
        default: rdata_ff <= {22'h0_0000, state_ff != APCU_H_IDLE, irq_seen_ff, cond_ff};
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sc_ff <= 8'h00;
      dh_ff <= 8'h00;
      cmd_ff <= 8'h00;
    end else if (wr_acc) begin
      if (avs_address_i == 2'h0) sc_ff <= avs_writedata_i[7:0];
      if (avs_address_i == 2'h1) dh_ff <= avs_writedata_i[7:0];
      if (avs_address_i == 2'h2 && state_ff == APCU_H_IDLE) cmd_ff <= avs_writedata_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Task-file sequencer: count, drive/head, then command, which starts it.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_ff <= APCU_H_IDLE;
      addr_ff <= 10'h000;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      wdata_ff <= 8'h00;
    end else begin
      wr_ff <= 1'b0;
      rd_ff <= 1'b1;
      addr_ff <= apcu_pkg::TF_STATUS;
      case (state_ff)
        APCU_H_IDLE: begin
          if (wr_acc && avs_address_i == 2'h2) state_ff <= APCU_H_SC;
        end
        APCU_H_SC: begin
          rd_ff <= 1'b0;
          wr_ff <= 1'b1;
          addr_ff <= apcu_pkg::TF_SECTOR_COUNT;
          wdata_ff <= sc_ff;
          state_ff <= APCU_H_DH;
        end
        APCU_H_DH: begin
          rd_ff <= 1'b0;
          wr_ff <= 1'b1;
          addr_ff <= apcu_pkg::TF_DRIVE_HEAD;
          wdata_ff <= dh_ff;
          state_ff <= APCU_H_CMD;
        end
        APCU_H_CMD: begin
          rd_ff <= 1'b0;
          wr_ff <= 1'b1;
          addr_ff <= apcu_pkg::TF_COMMAND;
          wdata_ff <= cmd_ff;
          state_ff <= APCU_H_IDLE;
        end
        default: state_ff <= APCU_H_IDLE;
      endcase
    end
  end

  // Status polling runs whenever the sequencer rests; set beats clear.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cond_ff <= 8'h00;
      irq_seen_ff <= 1'b0;
    end else begin
      if (rd_ff) cond_ff <= tf.rdata;
      if (tf.intrq) irq_seen_ff <= 1'b1;
      else if (wr_acc && avs_address_i == 2'h3) irq_seen_ff <= 1'b0;
    end
  end
endmodule

// ---- tb/apcu_checker.sv ----
/*
  Concurrent checks on the task-file link between host controller and device.
  Assumes one clock and a synchronous active-low reset shared by both ends.
*/
module apcu_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Task-file link
  input wire logic [9:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic intrq
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------------
  // Link events
  // ----------------------------------------------------------------------
  wire logic cmd_w = wr && (addr == apcu_pkg::TF_COMMAND);
  wire logic st_r = rd && (addr == apcu_pkg::TF_STATUS);

  sequence s_cmd;
    cmd_w && !intrq;
  endsequence

  sequence s_done;
    ##1 !intrq ##1 intrq;
  endsequence

  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_cmd_irq: assert property (s_cmd |-> s_done)
    else $error("interrupt missing two cycles after a command");
  a_irq_cause: assert property ($rose(intrq) |-> $past(cmd_w, 2))
    else $error("interrupt raised without a command");
  a_irq_hold: assert property (intrq && !st_r |=> intrq)
    else $error("interrupt dropped before a status read");
  // A fresh interrupt landing on the clearing edge wins over the clear.
  a_irq_clear: assert property (intrq && st_r && !$past(cmd_w) |=> !intrq)
    else $error("interrupt kept after a status read");
  a_busy_seen: assert property ($past(cmd_w) && !$past(intrq) && st_r |-> rdata[apcu_pkg::BUSY_BIT])
    else $error("busy not shown after a command");
  a_done_unbusy: assert property ($rose(intrq) && st_r |-> !rdata[apcu_pkg::BUSY_BIT])
    else $error("interrupt raised while still busy");
  a_ready_busy: assert property (st_r |-> rdata[apcu_pkg::READY_BIT] != rdata[apcu_pkg::BUSY_BIT])
    else $error("ready and busy not complementary");
  a_status_zero: assert property (st_r |-> rdata[5:0] == 6'h00)
    else $error("unused condition bits not zero");
endmodule

// ---- tb/tb_ata_power_mode_command_unit.sv ----
/*
  Self-checking bench: host and device ends joined by the task-file link,
  driven over Avalon-MM, with the spindle and seek inputs played by the bench.
  Assumes the device runs with a ten-cycle second so countdowns stay short.
*/
module tb_ata_power_mode_command_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 10;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic spin = 1'b0;
  logic seek = 1'b0;
  logic spin_up_req, spin_down_req, standby, auto_pd, seek_go;
  int fails = 0;
  int total_checks = 0;

  apcu_if tf ();
  apcu_host i_apcu_host (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest), .tf(tf));
  apcu_device #(.TICK_CYCLES(TICKS)) i_apcu_device (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tf(tf),
    .spindle_rotating_i(spin), .seek_cmd_i(seek), .spin_up_req_o(spin_up_req),
    .spin_down_req_o(spin_down_req), .standby_mode_o(standby), .auto_pd_en_o(auto_pd), .seek_go_o(seek_go));
  apcu_checker i_apcu_checker (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr(tf.addr), .wr(tf.wr),
    .rd(tf.rd), .wdata(tf.wdata), .rdata(tf.rdata), .intrq(tf.intrq));

  always #2.5 core_clk_i = ~core_clk_i;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // The request is held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic [1:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge core_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] sc, input logic [7:0] code);
    logic [31:0] q;
    int n;
    bus(2'h0, 1'b1, {24'h00_0000, sc}, q);
    bus(2'h1, 1'b1, 32'h0000_00a0, q);
    bus(2'h2, 1'b1, {24'h00_0000, code}, q);
    n = 0;
    do begin
      bus(2'h3, 1'b0, 32'h0000_0000, q);
      n++;
    end while (q[8] !== 1'b1 && n < 50);
    check("completion condition", {22'h0_0000, q[9:0]}, 32'h0000_0140);
    bus(2'h3, 1'b1, 32'h0000_0000, q);
  endtask

  task automatic watch(input int cyc, output logic up, output logic dn, output logic go);
    up = 1'b0;
    dn = 1'b0;
    go = 1'b0;
    repeat (cyc) begin
      @(posedge core_clk_i);
      up = up | spin_up_req;
      dn = dn | spin_down_req;
      go = go | seek_go;
    end
  endtask

  // Cycles are counted from the return of the command task, which lags the launch.
  task automatic timed(input int secs);
    int n;
    n = 0;
    while (standby !== 1'b1 && n < secs * TICKS + 100) begin
      @(posedge core_clk_i);
      n++;
    end
    check("countdown cycles", 32'(n > secs * TICKS - 40 && n < secs * TICKS + 15), 32'h0000_0001);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_codes();
    logic [7:0] codes [8] = '{apcu_pkg::CMD_IDLE_A, apcu_pkg::CMD_IDLE_B, apcu_pkg::CMD_IDLE_IMM_A,
      apcu_pkg::CMD_IDLE_IMM_B, apcu_pkg::CMD_STBY_A, apcu_pkg::CMD_STBY_B, apcu_pkg::CMD_STBY_IMM_A,
      apcu_pkg::CMD_STBY_IMM_B};
    logic [31:0] q;
    for (int i = 0; i < 8; i++) begin
      cmd(8'h00, codes[i]);
      check("standby mode", 32'(standby), 32'(i >= 4));
      check("auto power-down", 32'(auto_pd), 32'h0000_0000);
    end
    cmd(8'h00, 8'h00);
    check("standby after unknown code", 32'(standby), 32'h0000_0001);
    bus(2'h3, 1'b0, 32'h0000_0000, q);
    check("sticky interrupt", 32'(q[8]), 32'h0000_0000);
  endtask

  task automatic t_spindle();
    logic up, dn, go;
    fork
      cmd(8'h00, apcu_pkg::CMD_STBY_B);
      watch(40, up, dn, go);
    join
    check("spin-down when stopped", 32'(dn), 32'h0000_0000);
    spin <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    fork
      cmd(8'h00, apcu_pkg::CMD_IDLE_B);
      watch(40, up, dn, go);
    join
    check("spin-up when rotating", 32'(up), 32'h0000_0000);
    fork
      cmd(8'h00, apcu_pkg::CMD_STBY_A);
      watch(40, up, dn, go);
    join
    check("spin-down when rotating", 32'(dn), 32'h0000_0001);
    cmd(8'h00, apcu_pkg::CMD_IDLE_IMM_A);
  endtask

  task automatic t_auto();
    cmd(8'h01, apcu_pkg::CMD_IDLE_A);
    check("auto power-down on", 32'(auto_pd), 32'h0000_0001);
    timed(5);
    cmd(8'h00, apcu_pkg::CMD_IDLE_B);
    repeat (300) @(posedge core_clk_i);
    check("standby while disabled", 32'(standby), 32'h0000_0000);
    cmd(8'h01, apcu_pkg::CMD_IDLE_A);
    cmd(8'h00, apcu_pkg::CMD_IDLE_IMM_B);
    check("enable after idle now", 32'(auto_pd), 32'h0000_0001);
    cmd(8'h00, apcu_pkg::CMD_STBY_IMM_A);
    check("enable after standby now", 32'(auto_pd), 32'h0000_0001);
    cmd(8'h02, apcu_pkg::CMD_IDLE_A);
    repeat (60) @(posedge core_clk_i);
    cmd(8'h00, apcu_pkg::CMD_IDLE_IMM_A);
    timed(10);
  endtask

  task automatic t_seek();
    logic up, dn, go;
    int n;
    spin <= 1'b0;
    repeat (10) @(posedge core_clk_i);
    cmd(8'h01, apcu_pkg::CMD_STBY_A);
    check("armed in standby", {30'h000_0000, auto_pd, standby}, 32'h0000_0003);
    seek <= 1'b1;
    watch(30, up, dn, go);
    check("spin-up before seek", {30'h000_0000, up, go}, 32'h0000_0002);
    spin <= 1'b1;
    n = 0;
    while (seek_go !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    seek <= 1'b0;
    check("seek allowed", 32'(n < 50), 32'h0000_0001);
    repeat (3) @(posedge core_clk_i);
    check("back in idle", 32'(standby), 32'h0000_0000);
    timed(5);
  endtask

  task automatic t_decode();
    logic [7:0] sc_tab [6] = '{8'h02, 8'hf0, 8'hf1, 8'hfc, 8'hfe, 8'hff};
    int sec_tab [6] = '{10, 1200, 1800, 1260, 1275, 1275};
    for (int i = 0; i < 6; i++) begin
      cmd(sc_tab[i], apcu_pkg::CMD_IDLE_B);
      timed(sec_tab[i]);
    end
  endtask

  // ----------------------------------------------------------------------
  // Sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    t_codes();
    t_spindle();
    t_auto();
    t_seek();
    t_decode();
    end_sim();
  end

  initial begin
    #500us;
    fails++;
    end_sim();
  end
endmodule
